//--- src/mmd_cfg.svh
`ifndef MMD_CFG_SVH
`define MMD_CFG_SVH

// ============================================================
// address map
`define MMD_NVM_BASE      24'h00_0000
`define MMD_NVM_SIZE      24'h02_0000
`define MMD_OPT_BASE      24'h00_0000
`define MMD_RST_VEC_BASE  24'h00_0004
`define MMD_RAM_TOP       24'hff_bfff
`define MMD_RAM_SIZE      24'h00_1000
`define MMD_IO_BASE       24'hff_e000
`define MMD_IO_TOP        24'hff_ffff

// ============================================================
// core control registers inside the i/o region
`define MMD_PCL_BASE      24'hff_e004
`define MMD_SPL_BASE      24'hff_e00c
`define MMD_FLAGS_ADDR    24'hff_e010
`define MMD_CCTL_ADDR     24'hff_e012
`define MMD_PCL_RESET     32'h00ff_ffff
`define MMD_SPL_RESET     32'h0000_0000
`define MMD_FLAGS_RESET   8'h00
`define MMD_CCTL_RESET    8'h00

// ============================================================
// interrupt request block: groups of four bytes
`define MMD_IRQ_BASE      24'hff_e030
`define MMD_IRQ_LAST      24'hff_e03b

// ============================================================
// fill value for unpopulated addresses
`define MMD_EMPTY_BYTE    8'hff

`endif

//--- src/mmd_pkg.sv
package mmd_pkg;

    // ============================================================
    // access sizes and targets
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_QUAD = 2'h2
    } mmd_size_e;

    typedef enum logic [2:0] {
        TG_NONE = 3'h0,
        TG_NVM  = 3'h1,
        TG_RAM  = 3'h2,
        TG_PER  = 3'h3,
        TG_CTL  = 3'h4
    } mmd_tgt_e;

    // gray coded along idle -> run -> wait -> done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_WAIT = 2'b11,
        ST_DONE = 2'b10
    } mmd_st_e;

    // ============================================================
    // carriers
    typedef struct packed {
        logic [23:0] addr;
        mmd_size_e   size;
        logic        we;
        logic        fetch;
        logic [31:0] wdata;
    } mmd_cpu_req_s;

    typedef struct packed {
        logic [23:0] addr;
        logic        we;
        logic        fetch;
        logic [1:0]  be;
        logic [15:0] wdata;
    } mmd_bus_req_s;

    typedef struct packed {
        logic hit;
        logic wide;
    } mmd_per_map_s;

    typedef struct packed {
        logic       hit;
        logic [1:0] group;
        logic [1:0] reg_sel;
    } mmd_irq_sel_s;

    typedef struct packed {
        logic [31:0] pc_limit;
        logic [31:0] sp_limit;
        logic [7:0]  flags;
        logic [7:0]  core_ctl;
    } mmd_ctl_s;

    typedef struct packed {
        mmd_st_e      st;
        mmd_tgt_e     tgt;
        logic [23:0]  cur;
        logic [2:0]   rem;
        logic         we;
        logic         fetch;
        logic         wide;
        logic [1:0]   be;
        logic [15:0]  wd;
        logic [31:0]  wsh;
        logic [31:0]  acc;
        mmd_ctl_s     ctl;
    } mmd_state_s;

endpackage : mmd_pkg

//--- src/mmd_lane.sv
// ============================================================
// one 16-bit cycle: lane choice, write steering, read pick-up
module mmd_lane
    import mmd_pkg::*;
(
    input  wire logic        i_odd,
    input  wire logic [2:0]  i_rem,
    input  wire logic        i_wide,
    input  wire logic [15:0] i_wtop,
    input  wire logic [15:0] i_lane_rd,
    output logic             o_two,
    output logic [1:0]       o_be,
    output logic [15:0]      o_lane_wd,
    output logic [15:0]      o_rd
);

    // two bytes only on a wide target at an even cursor
    always_comb begin
        o_two = i_wide && !i_odd && (i_rem >= 3'h2);
        if (o_two) begin
            o_be      = 2'b11;
            o_lane_wd = i_wtop;
            o_rd      = i_lane_rd;
        end else if (i_odd) begin
            o_be      = 2'b01;
            o_lane_wd = {8'h00, i_wtop[15:8]};
            o_rd      = {8'h00, i_lane_rd[7:0]};
        end else begin
            o_be      = 2'b10;
            o_lane_wd = {i_wtop[15:8], 8'h00};
            o_rd      = {8'h00, i_lane_rd[15:8]};
        end
    end

endmodule : mmd_lane

//--- src/mmd_decoder.sv
// Notes on behaviour
// - one flat 24-bit address space
// - byte, word or quad transfers
// - top 8 KB is the i/o region
// - empty i/o reads return ff per byte
// - empty i/o writes change nothing
// - unimplemented peripheral registers act empty
// - ram ends ff_bfff, bottom from size
// - ram serves data and fetches
// - non-volatile memory starts at zero
// - multi-byte data is big endian
// - memory data paths are 16 bits
// - peripherals may be 8 or 16 bits
// - even word one cycle, quad two
// - odd word two cycles, quad three
// - core control registers at i/o bottom
// - core control registers have reset values
// - interrupt block in groups of four
`include "mmd_cfg.svh"

module mmd_decoder
    import mmd_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_req,
    input  wire mmd_cpu_req_s i_cpu,
    output logic              o_busy,
    output logic              o_ack,
    output logic [31:0]       o_rdata,
    output logic              o_mem_req,
    output logic              o_mem_ram,
    output mmd_bus_req_s      o_bus,
    input  wire logic         i_mem_ack,
    input  wire logic [15:0]  i_mem_rdata,
    output logic              o_per_req,
    input  wire mmd_per_map_s i_per_map,
    input  wire logic         i_per_ack,
    input  wire logic [15:0]  i_per_rdata,
    output mmd_irq_sel_s      o_irq_sel,
    output mmd_ctl_s          o_ctl
);

    // ============================================================
    // address decode
    localparam logic [23:0] RAM_BOT = `MMD_RAM_TOP - `MMD_RAM_SIZE
                                      + 24'h00_0001;

    function automatic logic is_ctl(input logic [23:0] a);
        is_ctl = (a[23:2] == `MMD_PCL_BASE >> 2)
              || (a[23:2] == `MMD_SPL_BASE >> 2)
              || (a == `MMD_FLAGS_ADDR)
              || (a == `MMD_CCTL_ADDR);
    endfunction : is_ctl

    // one region per address; gaps fall through to empty
    function automatic mmd_tgt_e tgt_of(input logic [23:0] a);
        if (a >= `MMD_IO_BASE && is_ctl(a)) begin
            tgt_of = TG_CTL;
        end else if (a >= `MMD_IO_BASE) begin
            tgt_of = TG_PER;
        end else if (a >= RAM_BOT && a <= `MMD_RAM_TOP) begin
            tgt_of = TG_RAM;
        end else if (a < `MMD_NVM_BASE + `MMD_NVM_SIZE) begin
            tgt_of = TG_NVM;
        end else begin
            tgt_of = TG_NONE;
        end
    endfunction : tgt_of

    // byte k of a big-endian 32-bit register
    function automatic logic [7:0] be_byte(input logic [31:0] r,
                                           input logic [1:0]  k);
        be_byte = r[8*(3-k) +: 8];
    endfunction : be_byte

    function automatic logic [7:0] ctl_read(input mmd_ctl_s c,
                                            input logic [23:0] a);
        if (a[23:2] == `MMD_PCL_BASE >> 2) begin
            ctl_read = be_byte(c.pc_limit, a[1:0]);
        end else if (a[23:2] == `MMD_SPL_BASE >> 2) begin
            ctl_read = be_byte(c.sp_limit, a[1:0]);
        end else if (a == `MMD_FLAGS_ADDR) begin
            ctl_read = c.flags;
        end else begin
            ctl_read = c.core_ctl;
        end
    endfunction : ctl_read

    // ============================================================
    // state
    mmd_state_s  s;
    mmd_state_s  next_s;
    mmd_tgt_e    tgt_now;
    logic        wide_now;
    logic        two;
    logic [1:0]  be;
    logic [15:0] lane_wd;
    logic [15:0] lane_rd;
    logic [15:0] rd_bytes;
    logic        bus_ack;

    // peripherals outside this variant are claimed by nobody
    always_comb begin
        tgt_now = tgt_of(s.cur);
        if (tgt_now == TG_PER && !i_per_map.hit) begin
            tgt_now = TG_NONE;
        end
        wide_now = (tgt_now == TG_NVM) || (tgt_now == TG_RAM)
                || (tgt_now == TG_PER && i_per_map.wide);
    end

    assign lane_rd = (s.tgt == TG_PER) ? i_per_rdata : i_mem_rdata;
    assign bus_ack = (s.tgt == TG_PER) ? i_per_ack : i_mem_ack;

    mmd_lane u_lane (
        .i_odd     (s.cur[0]),
        .i_rem     (s.rem),
        .i_wide    ((s.st == ST_WAIT) ? s.wide : wide_now),
        .i_wtop    (s.wsh[31:16]),
        .i_lane_rd (lane_rd),
        .o_two     (two),
        .o_be      (be),
        .o_lane_wd (lane_wd),
        .o_rd      (rd_bytes)
    );

    // ============================================================
    // access sequencer: one cycle per lane group until done
    always_comb begin
        logic [7:0] rbyte;
        logic [2:0] nb;
        rbyte  = `MMD_EMPTY_BYTE;
        nb     = two ? 3'h2 : 3'h1;
        next_s = s;
        case (s.st)
            ST_IDLE: begin
                if (i_req) begin
                    next_s.cur   = i_cpu.addr;
                    next_s.we    = i_cpu.we;
                    next_s.fetch = i_cpu.fetch;
                    next_s.acc   = 32'h0000_0000;
                    case (i_cpu.size)
                        SZ_WORD: begin
                            next_s.rem = 3'h2;
                            next_s.wsh = {i_cpu.wdata[15:0], 16'h0000};
                        end
                        SZ_QUAD: begin
                            next_s.rem = 3'h4;
                            next_s.wsh = i_cpu.wdata;
                        end
                        default: begin
                            next_s.rem = 3'h1;
                            next_s.wsh = {i_cpu.wdata[7:0], 24'h00_0000};
                        end
                    endcase
                    next_s.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (tgt_now == TG_NVM || tgt_now == TG_RAM
                        || tgt_now == TG_PER) begin
                    next_s.tgt  = tgt_now;
                    next_s.wide = wide_now;
                    next_s.be   = be;
                    next_s.wd   = s.we ? lane_wd : 16'h0000;
                    next_s.st   = ST_WAIT;
                end else begin
                    // internal or empty byte finishes in this cycle
                    if (tgt_now == TG_CTL) begin
                        rbyte = ctl_read(s.ctl, s.cur);
                    end
                    if (s.we && tgt_now == TG_CTL) begin
                        if (s.cur[23:2] == `MMD_PCL_BASE >> 2) begin
                            next_s.ctl.pc_limit[8*(3-s.cur[1:0]) +: 8] =
                                s.wsh[31:24];
                        end else if (s.cur[23:2] == `MMD_SPL_BASE >> 2) begin
                            next_s.ctl.sp_limit[8*(3-s.cur[1:0]) +: 8] =
                                s.wsh[31:24];
                        end else if (s.cur == `MMD_FLAGS_ADDR) begin
                            next_s.ctl.flags = s.wsh[31:24];
                        end else begin
                            next_s.ctl.core_ctl = s.wsh[31:24];
                        end
                    end
                    next_s.acc = {s.acc[23:0], rbyte};
                    next_s.cur = s.cur + 24'h00_0001;
                    next_s.rem = s.rem - 3'h1;
                    next_s.wsh = {s.wsh[23:0], 8'h00};
                    next_s.st  = (s.rem == 3'h1) ? ST_DONE : ST_RUN;
                end
            end
            ST_WAIT: begin
                if (bus_ack) begin
                    if (two) begin
                        next_s.acc = {s.acc[15:0], rd_bytes};
                        next_s.wsh = {s.wsh[15:0], 16'h0000};
                    end else begin
                        next_s.acc = {s.acc[23:0], rd_bytes[7:0]};
                        next_s.wsh = {s.wsh[23:0], 8'h00};
                    end
                    next_s.cur = s.cur + {21'h00_0000, nb};
                    next_s.rem = s.rem - nb;
                    next_s.tgt = TG_NONE;
                    next_s.st  = (s.rem == nb) ? ST_DONE : ST_RUN;
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
    end

    // ============================================================
    // state register; control registers take their reset values
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s              <= '0;
            s.st           <= ST_IDLE;
            s.tgt          <= TG_NONE;
            s.ctl.pc_limit <= `MMD_PCL_RESET;
            s.ctl.sp_limit <= `MMD_SPL_RESET;
            s.ctl.flags    <= `MMD_FLAGS_RESET;
            s.ctl.core_ctl <= `MMD_CCTL_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ============================================================
    // outputs: handshakes from state, data and addresses from flops
    assign o_busy    = (s.st != ST_IDLE);
    assign o_ack     = (s.st == ST_DONE);
    assign o_rdata   = s.acc;
    assign o_mem_req = (s.st == ST_WAIT)
                    && (s.tgt == TG_NVM || s.tgt == TG_RAM);
    assign o_mem_ram = (s.tgt == TG_RAM);
    assign o_per_req = (s.st == ST_WAIT) && (s.tgt == TG_PER);
    assign o_ctl     = s.ctl;

    // bus carries the cursor; memories use the even word address
    always_comb begin
        o_bus.addr  = s.cur;
        o_bus.we    = s.we;
        o_bus.fetch = s.fetch;
        o_bus.be    = s.be;
        o_bus.wdata = s.wd;
    end

    // interrupt block: group from bits 3:2, register from bits 1:0
    always_comb begin
        o_irq_sel.hit     = (s.cur >= `MMD_IRQ_BASE)
                         && (s.cur <= `MMD_IRQ_LAST);
        o_irq_sel.group   = s.cur[3:2];
        o_irq_sel.reg_sel = s.cur[1:0];
    end

endmodule : mmd_decoder

//--- verification/mmd_decoder_assertions.sv
`include "mmd_cfg.svh"

module mmd_decoder_assertions
    import mmd_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_req,
    input  wire logic         o_busy,
    input  wire logic         o_ack,
    input  wire logic         o_mem_req,
    input  wire logic         o_mem_ram,
    input  wire mmd_bus_req_s o_bus,
    input  wire logic         i_mem_ack,
    input  wire logic         o_per_req,
    input  wire mmd_irq_sel_s o_irq_sel
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // ============================================================
    // address windows seen by the cursor
    logic ram_hit;
    logic irq_win;
    assign ram_hit = (o_bus.addr >= (`MMD_RAM_TOP - `MMD_RAM_SIZE + 24'h1))
                  && (o_bus.addr <= `MMD_RAM_TOP);
    assign irq_win = o_per_req && (o_bus.addr >= `MMD_IRQ_BASE)
                  && (o_bus.addr <= `MMD_IRQ_LAST);

    // ============================================================
    // handshake steps
    sequence s_take;
        i_req && !o_busy;
    endsequence
    sequence s_mem_wait;
        o_mem_req && !i_mem_ack;
    endsequence
    sequence s_mem_done;
        o_mem_req && i_mem_ack;
    endsequence

    take_sets_busy_a: assert property (s_take |=> o_busy)
        else $error("request taken without busy");
    ack_single_a: assert property (o_ack |=> !o_ack && !o_busy)
        else $error("ack not a single closing pulse");
    ack_in_busy_a: assert property (o_ack |-> o_busy)
        else $error("ack outside busy");
    mem_hold_a: assert property (s_mem_wait |=>
        o_mem_req && $stable(o_bus))
        else $error("memory request changed before ack");
    mem_drop_a: assert property (s_mem_done |=> !o_mem_req)
        else $error("memory request held after ack");
    ram_select_a: assert property (o_mem_req |-> o_mem_ram == ram_hit)
        else $error("ram select disagrees with address");
    gap_no_mem_a: assert property (o_mem_req |->
        ram_hit || o_bus.addr < `MMD_NVM_SIZE)
        else $error("memory cycle into a gap");
    per_in_io_a: assert property (o_per_req |->
        o_bus.addr >= `MMD_IO_BASE)
        else $error("peripheral cycle below i/o");
    byte_lane_a: assert property (o_mem_req && o_bus.be != 2'h3 |->
        o_bus.be == (o_bus.addr[0] ? 2'h1 : 2'h2))
        else $error("byte lane wrong");
    wide_even_a: assert property (o_mem_req && o_bus.be == 2'h3 |->
        !o_bus.addr[0])
        else $error("wide cycle at odd address");
    irq_route_a: assert property (irq_win |->
        o_irq_sel == {1'b1, o_bus.addr[3:2], o_bus.addr[1:0]})
        else $error("irq select wrong");
endmodule : mmd_decoder_assertions

//--- verification/mmd_far_model.sv
module mmd_far_model
    import mmd_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_slow,
    input  wire logic         i_mem_req,
    input  wire logic         i_mem_ram,
    input  wire mmd_bus_req_s i_bus,
    input  wire logic         i_per_req,
    output logic              o_mem_ack,
    output logic [15:0]       o_mem_rdata,
    output mmd_per_map_s      o_per_map,
    output logic              o_per_ack,
    output logic [15:0]       o_per_rdata
);
    logic [7:0]  ram [0:4095];
    logic [7:0]  per [0:255];
    logic [1:0]  wt;
    logic [23:0] a;
    logic [15:0] d;

    // one wide pair at ff_e100 and the narrow irq block; rest empty
    assign o_per_map.wide = i_bus.addr[23:1] == 23'h7f_f080;
    assign o_per_map.hit  = o_per_map.wide || (i_bus.addr >= 24'hff_e030
                         && i_bus.addr <= 24'hff_e03b);
    assign a = {i_bus.addr[23:1], 1'b0};

    // 16-bit word, even byte on the upper lane; nvm is a fixed pattern
    always_comb begin
        if (i_per_req) begin
            d = {per[a[7:0]], per[a[7:0] + 8'h1]};
        end else if (i_mem_ram) begin
            d = {ram[a[11:0]], ram[a[11:0] + 12'h1]};
        end else begin
            d = {a[7:0] ^ 8'h3c, (a[7:0] + 8'h1) ^ 8'h3c};
        end
    end

    // slow mode adds three waits; idle data toggles so stale reads show
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_mem_ack   <= 1'b0;
            o_per_ack   <= 1'b0;
            o_mem_rdata <= 16'h0;
            o_per_rdata <= 16'h0;
            wt          <= 2'h0;
        end else begin
            o_mem_ack <= 1'b0;
            o_per_ack <= 1'b0;
            if ((i_mem_req || i_per_req) && !o_mem_ack && !o_per_ack) begin
                if (i_slow && wt != 2'h3) begin
                    wt <= wt + 2'h1;
                end else begin
                    wt          <= 2'h0;
                    o_mem_ack   <= i_mem_req;
                    o_per_ack   <= i_per_req;
                    o_mem_rdata <= d;
                    o_per_rdata <= d;
                    if (i_bus.we && i_per_req) begin
                        if (i_bus.be[1]) begin
                            per[a[7:0]] <= i_bus.wdata[15:8];
                        end
                        if (i_bus.be[0]) begin
                            per[a[7:0] + 8'h1] <= i_bus.wdata[7:0];
                        end
                    end
                    if (i_bus.we && i_mem_req && i_mem_ram) begin
                        if (i_bus.be[1]) begin
                            ram[a[11:0]] <= i_bus.wdata[15:8];
                        end
                        if (i_bus.be[0]) begin
                            ram[a[11:0] + 12'h1] <= i_bus.wdata[7:0];
                        end
                    end
                end
            end else begin
                o_mem_rdata <= ~o_mem_rdata;
                o_per_rdata <= ~o_per_rdata;
            end
        end
    end
endmodule : mmd_far_model

//--- verification/mmd_decoder_tb.sv
module mmd_decoder_tb
    import mmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         i_clk, i_sys_rst, i_req, slow, fch;
    logic         busy, ack, mreq, mram, mack, preq, pack;
    logic [31:0]  rdata, ncyc, fcyc;
    logic [15:0]  mrd, prd;
    mmd_cpu_req_s i_cpu;
    mmd_bus_req_s bus;
    mmd_per_map_s pmap;
    mmd_irq_sel_s irq;
    mmd_ctl_s     ctl;
    int           err_count = 0;
    int           tests_run = 0;

    mmd_decoder dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req),
        .i_cpu(i_cpu), .o_busy(busy), .o_ack(ack), .o_rdata(rdata),
        .o_mem_req(mreq), .o_mem_ram(mram), .o_bus(bus),
        .i_mem_ack(mack), .i_mem_rdata(mrd), .o_per_req(preq),
        .i_per_map(pmap), .i_per_ack(pack), .i_per_rdata(prd),
        .o_irq_sel(irq), .o_ctl(ctl));

    mmd_far_model far (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_slow(slow),
        .i_mem_req(mreq), .i_mem_ram(mram), .i_bus(bus), .i_per_req(preq),
        .o_mem_ack(mack), .o_mem_rdata(mrd), .o_per_map(pmap),
        .o_per_ack(pack), .o_per_rdata(prd));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // ============================================================
    // count of completed far-side handshakes; each access takes a difference
    always @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fcyc <= 32'h0;
        end else if (mreq && mack || preq && pack) begin
            fcyc <= fcyc + 32'h1;
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    // request held one edge, then wait for the closing pulse
    task automatic acc(input logic [23:0] a, input mmd_size_e s,
                       input logic w, input logic [31:0] d);
        int n;
        logic [31:0] c0;
        n = 0;
        @(negedge i_clk);
        i_cpu = '{a, s, w, fch, d};
        i_req = 1'b1;
        c0    = fcyc;
        @(negedge i_clk);
        i_req = 1'b0;
        while (ack !== 1'b1 && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        ncyc = fcyc - c0;
        chk({31'h0, ack}, 32'h1);
    endtask : acc

    task automatic rd(input logic [23:0] a, input mmd_size_e s,
                      input logic [31:0] e, input logic [31:0] n);
        acc(a, s, 1'b0, 32'h0);
        chk(rdata, e);
        chk(ncyc, n);
    endtask : rd

    task automatic wr(input logic [23:0] a, input mmd_size_e s,
                      input logic [31:0] d, input logic [31:0] n);
        acc(a, s, 1'b1, d);
        chk(ncyc, n);
    endtask : wr

    // ============================================================
    // scenarios
    task automatic t_reset;
        chk(ctl.pc_limit, 32'h00ff_ffff);
        chk(ctl.sp_limit, 32'h0);
        chk({24'h0, ctl.core_ctl}, 32'h0);
        rd(24'hff_e004, SZ_QUAD, 32'h00ff_ffff, 32'h0);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_ram;
        wr(24'hff_b001, SZ_QUAD, 32'h1122_3344, 32'h3);
        rd(24'hff_b001, SZ_QUAD, 32'h1122_3344, 32'h3);
        rd(24'hff_b002, SZ_WORD, 32'h2233, 32'h1);
        rd(24'hff_b003, SZ_WORD, 32'h3344, 32'h2);
        wr(24'hff_b002, SZ_BYTE, 32'haa, 32'h1);
        rd(24'hff_b004, SZ_BYTE, 32'h44, 32'h1);
        fch = 1'b1;
        rd(24'hff_b001, SZ_QUAD, 32'h11aa_3344, 32'h3);
        chk({31'h0, bus.fetch}, 32'h1);
        fch  = 1'b0;
        slow = 1'b1;
        wr(24'hff_b005, SZ_BYTE, 32'h55, 32'h1);
        rd(24'hff_b002, SZ_QUAD, 32'haa33_4455, 32'h2);
        slow = 1'b0;
        $display("t_ram done");
    endtask : t_ram

    task automatic t_nvm;
        rd(24'h00_0004, SZ_QUAD, 32'h3839_3a3b, 32'h2);
        rd(24'h00_0011, SZ_WORD, 32'h2d2e, 32'h2);
        $display("t_nvm done");
    endtask : t_nvm

    task automatic t_empty;
        rd(24'h02_0000, SZ_QUAD, 32'hffff_ffff, 32'h0);
        rd(24'hff_afff, SZ_BYTE, 32'hff, 32'h0);
        wr(24'hff_c000, SZ_BYTE, 32'h12, 32'h0);
        rd(24'hff_c000, SZ_BYTE, 32'hff, 32'h0);
        wr(24'hff_e200, SZ_WORD, 32'h5a5a, 32'h0);
        rd(24'hff_e200, SZ_WORD, 32'hffff, 32'h0);
        rd(24'hff_e03c, SZ_BYTE, 32'hff, 32'h0);
        $display("t_empty done");
    endtask : t_empty

    // every control register here is read/write
    task automatic t_ctl;
        wr(24'hff_e012, SZ_BYTE, 32'ha5, 32'h0);
        chk({24'h0, ctl.core_ctl}, 32'ha5);
        wr(24'hff_e00c, SZ_QUAD, 32'h1234_5678, 32'h0);
        chk(ctl.sp_limit, 32'h1234_5678);
        rd(24'hff_e00d, SZ_WORD, 32'h3456, 32'h0);
        $display("t_ctl done");
    endtask : t_ctl

    task automatic t_per;
        wr(24'hff_e100, SZ_WORD, 32'hbeef, 32'h1);
        rd(24'hff_e100, SZ_WORD, 32'hbeef, 32'h1);
        wr(24'hff_e036, SZ_WORD, 32'h1234, 32'h2);
        rd(24'hff_e036, SZ_WORD, 32'h1234, 32'h2);
        $display("t_per done");
    endtask : t_per

    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    // 26 accesses of under 20 cycles each; far more is a hang
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        final_report();
    end

    initial begin
        i_sys_rst = 1'b1;
        i_req     = 1'b0;
        i_cpu     = '0;
        slow      = 1'b0;
        fch       = 1'b0;
        repeat (12) @(posedge i_clk);
        @(negedge i_clk);
        i_sys_rst = 1'b0;
        t_reset();
        t_ram();
        t_nvm();
        t_empty();
        t_ctl();
        t_per();
        final_report();
    end
endmodule : mmd_decoder_tb

bind mmd_decoder mmd_decoder_assertions u_chk (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_req(i_req), .o_busy(o_busy), .o_ack(o_ack),
    .o_mem_req(o_mem_req), .o_mem_ram(o_mem_ram), .o_bus(o_bus),
    .i_mem_ack(i_mem_ack), .o_per_req(o_per_req), .o_irq_sel(o_irq_sel));
